//--- shared/cpu_ctl_map.svh
// Offsets-free constant set for the core control register file:
// status word field masks, reset values and pointer arithmetic steps.
// Assumes the includer has the matching package in scope for types.
`ifndef CPU_CTL_MAP_SVH
`define CPU_CTL_MAP_SVH

// Bits that a full-privilege status word load may change
`define SW_WRITE_MASK 32'h7FFF1FFF
// Bits that a user DSP mode status word load may change
`define SW_USER_DSP_MASK 32'h0FFF0C00
`define SW_RESET 32'h700000F0
`define VTB_RESET 32'h00000000
`define CREG_RESET 32'h00000000
`define PTR_STEP 32'h00000004
`define DISP_SHIFT 1
`define INSN_BYTES 32'h00000002
`define RF_ONE 2'h0
`define RF_TWO 2'h1
`define RF_THREE 2'h3
`define RF_MANY 2'h2

`endif

//--- shared/cpu_ctl_pkg.sv
// Types shared by the control register file and its neighbours.
// Assumes cpu_ctl_map.svh supplies the numeric constants.
package cpu_ctl_pkg;

    typedef struct packed {
        logic rsv31;
        logic privilege_bit;
        logic bank_select;
        logic event_mask_bit;
        logic [11:0] loop_count;
        logic [2:0] rsv15;
        logic vector_math_enable;
        logic y_wrap_enable;
        logic x_wrap_enable;
        logic m_flag;
        logic q_flag;
        logic [3:0] int_level;
        logic [1:0] loop_size_code;
        logic sat_flag;
        logic tf_flag;
    } sw_s;

    typedef enum logic [2:0] {
        OP_LDC, OP_LDC_MEM, OP_STC, OP_STC_MEM, OP_LOAD_BEGIN_OP, OP_LOAD_LAST_OP, OP_SET_LOOP_COUNT_OP
    } op_e;

    typedef enum logic [2:0] {
        CR_STATUS, CR_SAVED_STATUS, CR_SAVED_PC, CR_GLOBAL_BASE,
        CR_VECTOR_BASE, CR_REPEAT_BEGIN, CR_LOOP_LAST, CR_BOUNDS
    } creg_e;

    typedef enum logic [1:0] {
        MV_X, MV_Y, MV_SINGLE, MV_NONE
    } mv_e;

    typedef struct packed {
        logic valid;
        op_e op;
        creg_e sel;
        logic [31:0] wdata;
        logic [31:0] ptr;
        logic [31:0] pc;
        logic [7:0] disp;
        logic [11:0] count;
        logic [7:0] body_len;
    } ctl_req_s;

    typedef struct packed {
        logic done;
        logic illegal;
        logic [31:0] rdata;
        logic ptr_we;
        logic [31:0] ptr;
    } ctl_rsp_s;

    typedef struct packed {
        logic valid;
        mv_e kind;
        logic [31:0] addr;
    } agu_req_s;

    typedef struct packed {
        logic valid;
        logic wrapped;
        logic [31:0] addr;
    } agu_rsp_s;

    typedef struct packed {
        logic valid;
        logic [31:0] target;
    } redirect_s;

    typedef struct packed {
        sw_s sw;
        logic [31:0] ssw;
        logic [31:0] saved_program_counter;
        logic [31:0] gbp;
        logic [31:0] vtb;
        logic [31:0] rbp;
        logic [31:0] llp;
        logic [31:0] cb;
        ctl_rsp_s rsp;
        agu_rsp_s agu;
        redirect_s redir;
    } ctl_state_s;

endpackage

//--- hw/cpu_ctl_regs.sv
// Control register file of a 32-bit core with a DSP extension: status
// word, saved status and PC, base pointers, repeat pointers, bounds.
// Assumes the core decoder presents one control request per cycle and
// that exception entry and address generation arrive on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "cpu_ctl_map.svh"

// Contract
// - DSP behaviour only while vector_math_enable is 1.
// - x_wrap_enable makes X pointer wrap on circular_bounds.
// - y_wrap_enable makes Y pointer wrap on circular_bounds.
// - Both wrap enables set: only Y pointer wraps.
// - Wrapping applies to X and Y moves, never single moves.
// - loop_size_code 00=1, 01=2, 11=3, 10=four or more instructions.
// - set_loop_count_op sets loop_size_code from body length.
// - status_word holds a 12-bit loop_count repeat counter.
// - Status word load may also write loop_count and loop_size_code.
// - Wrap enables and loop_count writable in supervisor and user DSP.
// - circular_bounds holds wrap_end high, wrap_start low.
// - Pointer equal to wrap_end is replaced with wrap_start.
// - load_begin/load_last write displacement times two plus PC.
// - Memory load post-increments source by 4; store pre-decrements by 4.
// - Exception copies status_word into saved_status_word.
// - Exception copies PC into saved_program_counter.
// - vector_table_base gives the exception vector base.
// - User non-DSP status word load or store is an invalid instruction.
// - Supervisor DSP mode has full status word access.
// - User DSP mode store reads status_word freely.
// - User DSP load changes only loop_count and wrap enables.
// - Reserved bits read 0.
// - T flag reports carry, borrow, overflow, underflow.
// - global_base_pointer supplies base for peripheral area addressing.
// - Reset: privilege, bank, event mask 1, level 1111, count and DSP 0.
// - Forbidden field writes keep old value without exception.
module cpu_ctl_regs (
    input wire logic mclk,
    input wire logic srst,
    input wire cpu_ctl_pkg::ctl_req_s ctl_req,
    input wire logic exc_take,
    input wire logic [31:0] exc_pc,
    input wire logic tf_we,
    input wire logic tf_val,
    input wire cpu_ctl_pkg::agu_req_s agu_req,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_pc,
    output cpu_ctl_pkg::ctl_rsp_s ctl_rsp,
    output cpu_ctl_pkg::agu_rsp_s agu_rsp,
    output cpu_ctl_pkg::redirect_s loop_redirect,
    output cpu_ctl_pkg::sw_s status_word,
    output logic [31:0] global_base_pointer,
    output logic [31:0] vector_table_base,
    output logic dsp_active
);
    import cpu_ctl_pkg::*;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    function automatic logic [1:0] size_code(input logic [7:0] len);
        if (len <= 8'h01) begin
            size_code = `RF_ONE;
        end else if (len == 8'h02) begin
            size_code = `RF_TWO;
        end else if (len == 8'h03) begin
            size_code = `RF_THREE;
        end else begin
            size_code = `RF_MANY;
        end
    endfunction

    // Short loops end a fixed number of instructions after the start,
    // so the last pointer is only consulted for long bodies.
    function automatic logic [31:0] loop_end(input logic [1:0] code,
                                             input logic [31:0] first,
                                             input logic [31:0] last);
        unique case (code)
            `RF_ONE: loop_end = first;
            `RF_TWO: loop_end = first + `INSN_BYTES;
            `RF_THREE: loop_end = first + (`INSN_BYTES << 1);
            `RF_MANY: loop_end = last;
        endcase
    endfunction

    function automatic logic [31:0] pc_rel(input logic [31:0] pc,
                                           input logic [7:0] disp);
        logic [31:0] ext;
        ext = {{24{disp[7]}}, disp};
        pc_rel = pc + (ext << `DISP_SHIFT);
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************

    ctl_state_s st_r;
    ctl_state_s st_nxt;

    logic user_mode;
    logic sw_access;
    logic is_load;
    logic is_store;
    logic [31:0] sel_val;
    logic [31:0] sw_merged;
    logic wrap_x;
    logic wrap_y;
    logic [31:0] cur_end;

    always_comb begin
        user_mode = ~st_r.sw.privilege_bit;
        is_load = ctl_req.op == OP_LDC || ctl_req.op == OP_LDC_MEM;
        is_store = ctl_req.op == OP_STC || ctl_req.op == OP_STC_MEM;
        sw_access = ctl_req.valid && ctl_req.sel == CR_STATUS && (is_load || is_store);
        unique case (ctl_req.sel)
            CR_STATUS: sel_val = st_r.sw & `SW_WRITE_MASK;
            CR_SAVED_STATUS: sel_val = st_r.ssw;
            CR_SAVED_PC: sel_val = st_r.saved_program_counter;
            CR_GLOBAL_BASE: sel_val = st_r.gbp;
            CR_VECTOR_BASE: sel_val = st_r.vtb;
            CR_REPEAT_BEGIN: sel_val = st_r.rbp;
            CR_LOOP_LAST: sel_val = st_r.llp;
            CR_BOUNDS: sel_val = st_r.cb;
        endcase
        // User DSP loads only touch count and wrap enables; the rest of
        // the word keeps its old value silently.
        if (st_r.sw.privilege_bit) begin
            sw_merged = ctl_req.wdata & `SW_WRITE_MASK;
        end else begin
            sw_merged = (st_r.sw & ~`SW_USER_DSP_MASK)
                      | (ctl_req.wdata & `SW_USER_DSP_MASK);
        end
        // Y takes precedence when both enables are set
        wrap_y = st_r.sw.vector_math_enable && st_r.sw.y_wrap_enable;
        wrap_x = st_r.sw.vector_math_enable && st_r.sw.x_wrap_enable
               && !st_r.sw.y_wrap_enable;
        cur_end = loop_end(st_r.sw.loop_size_code, st_r.rbp, st_r.llp);
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp.done = 1'b0;
        st_nxt.rsp.illegal = 1'b0;
        st_nxt.rsp.ptr_we = 1'b0;
        st_nxt.redir.valid = 1'b0;
        st_nxt.agu.valid = 1'b0;
        st_nxt.agu.wrapped = 1'b0;

        if (tf_we) begin
            st_nxt.sw.tf_flag = tf_val;
        end

        // ****************************************************************
        // Hardware repeat
        // ****************************************************************
        if (fetch_valid && st_r.sw.vector_math_enable && st_r.sw.loop_count != 12'h000
            && fetch_pc == cur_end) begin
            st_nxt.redir.valid = 1'b1;
            st_nxt.redir.target = st_r.rbp;
            st_nxt.sw.loop_count = st_r.sw.loop_count - 12'h001;
        end

        // ****************************************************************
        // Operand address wrap
        // ****************************************************************
        if (agu_req.valid) begin
            st_nxt.agu.valid = 1'b1;
            st_nxt.agu.addr = agu_req.addr;
            if (((agu_req.kind == MV_X && wrap_x) || (agu_req.kind == MV_Y && wrap_y))
                && agu_req.addr[15:0] == st_r.cb[31:16]) begin
                st_nxt.agu.addr = {agu_req.addr[31:16], st_r.cb[15:0]};
                st_nxt.agu.wrapped = 1'b1;
            end
        end

        // ****************************************************************
        // Control requests; exception entry overrides them
        // ****************************************************************
        if (ctl_req.valid && !exc_take) begin
            st_nxt.rsp.done = 1'b1;
            if (sw_access && user_mode && !st_r.sw.vector_math_enable) begin
                st_nxt.rsp.illegal = 1'b1;
            end else begin
                unique case (ctl_req.op)
                    OP_LDC, OP_LDC_MEM: begin
                        unique case (ctl_req.sel)
                            CR_STATUS: st_nxt.sw = sw_merged;
                            CR_SAVED_STATUS: st_nxt.ssw = ctl_req.wdata;
                            CR_SAVED_PC: st_nxt.saved_program_counter = ctl_req.wdata;
                            CR_GLOBAL_BASE: st_nxt.gbp = ctl_req.wdata;
                            CR_VECTOR_BASE: st_nxt.vtb = ctl_req.wdata;
                            CR_REPEAT_BEGIN: st_nxt.rbp = ctl_req.wdata;
                            CR_LOOP_LAST: st_nxt.llp = ctl_req.wdata;
                            CR_BOUNDS: st_nxt.cb = ctl_req.wdata;
                        endcase
                        if (ctl_req.op == OP_LDC_MEM) begin
                            st_nxt.rsp.ptr_we = 1'b1;
                            st_nxt.rsp.ptr = ctl_req.ptr + `PTR_STEP;
                        end
                    end
                    OP_STC, OP_STC_MEM: begin
                        st_nxt.rsp.rdata = sel_val;
                        if (ctl_req.op == OP_STC_MEM) begin
                            st_nxt.rsp.ptr_we = 1'b1;
                            st_nxt.rsp.ptr = ctl_req.ptr - `PTR_STEP;
                        end
                    end
                    OP_LOAD_BEGIN_OP: st_nxt.rbp = pc_rel(ctl_req.pc, ctl_req.disp);
                    OP_LOAD_LAST_OP: st_nxt.llp = pc_rel(ctl_req.pc, ctl_req.disp);
                    OP_SET_LOOP_COUNT_OP: begin
                        st_nxt.sw.loop_count = ctl_req.count;
                        st_nxt.sw.loop_size_code = size_code(ctl_req.body_len);
                    end
                    // The one unused op code only raises done
                    default: begin
                    end
                endcase
            end
        end

        if (exc_take) begin
            st_nxt.ssw = st_r.sw;
            st_nxt.saved_program_counter = exc_pc;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r <= '0;
            st_r.sw <= `SW_RESET;
            st_r.vtb <= `VTB_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ctl_rsp = st_r.rsp;
    assign agu_rsp = st_r.agu;
    assign loop_redirect = st_r.redir;
    assign status_word = st_r.sw;
    assign global_base_pointer = st_r.gbp;
    assign vector_table_base = st_r.vtb;
    assign dsp_active = st_r.sw.vector_math_enable;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb_main @(posedge mclk); endclocking
    default disable iff (srst);

    sequence s_loop_hit;
        fetch_valid && st_r.sw.vector_math_enable && st_r.sw.loop_count != 12'h000
        && fetch_pc == cur_end && !(ctl_req.valid && ctl_req.op == OP_SET_LOOP_COUNT_OP)
        && !(ctl_req.valid && is_load && ctl_req.sel == CR_STATUS);
    endsequence

    sequence s_loop_taken;
        loop_redirect.valid && loop_redirect.target == $past(st_r.rbp);
    endsequence

    property p_reset_state;
        $fell(srst) |-> status_word.privilege_bit && status_word.bank_select
            && status_word.event_mask_bit && status_word.int_level == 4'hF
            && status_word.loop_count == 12'h000 && !dsp_active;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad reset state");

    property p_user_illegal;
        ctl_req.valid && !exc_take && sw_access && user_mode && !dsp_active
        |=> ctl_rsp.illegal && $stable(status_word);
    endproperty
    a_user_illegal: assert property (p_user_illegal) else $error("no invalid trap");

    property p_user_dsp_load;
        ctl_req.valid && !exc_take && is_load && ctl_req.sel == CR_STATUS
        && user_mode && dsp_active && !tf_we
        |=> status_word.privilege_bit == $past(status_word.privilege_bit)
            && status_word.int_level == $past(status_word.int_level)
            && status_word.loop_size_code == $past(status_word.loop_size_code)
            && status_word.x_wrap_enable == $past(ctl_req.wdata[10])
            && !ctl_rsp.illegal;
    endproperty
    a_user_dsp_load: assert property (p_user_dsp_load) else $error("user dsp load");

    property p_exc_save;
        exc_take |=> st_r.ssw == $past(st_r.sw) && st_r.saved_program_counter == $past(exc_pc);
    endproperty
    a_exc_save: assert property (p_exc_save) else $error("exception save wrong");

    property p_pc_rel;
        ctl_req.valid && !exc_take && ctl_req.op == OP_LOAD_BEGIN_OP
        |=> st_r.rbp == $past(ctl_req.pc) + {{23{$past(ctl_req.disp[7])}},
            $past(ctl_req.disp), 1'b0};
    endproperty
    a_pc_rel: assert property (p_pc_rel) else $error("begin pointer wrong");

    property p_ptr_step;
        ctl_req.valid && !exc_take && !sw_access && ctl_req.op == OP_STC_MEM
        |=> ctl_rsp.ptr_we && ctl_rsp.ptr == $past(ctl_req.ptr) - 32'h00000004;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("store step wrong");

    property p_wrap;
        agu_req.valid && agu_req.kind == MV_Y && dsp_active && status_word.y_wrap_enable
        && agu_req.addr[15:0] == st_r.cb[31:16]
        |=> agu_rsp.wrapped && agu_rsp.addr[15:0] == $past(st_r.cb[15:0]);
    endproperty
    a_wrap: assert property (p_wrap) else $error("missing wrap");

    property p_no_wrap;
        agu_req.valid && (agu_req.kind == MV_SINGLE
            || (agu_req.kind == MV_X && status_word.y_wrap_enable))
        |=> !agu_rsp.wrapped && agu_rsp.addr == $past(agu_req.addr);
    endproperty
    a_no_wrap: assert property (p_no_wrap) else $error("illegal wrap");

    property p_set_loop_count_op;
        ctl_req.valid && !exc_take && ctl_req.op == OP_SET_LOOP_COUNT_OP && ctl_req.body_len == 8'h03
        |=> status_word.loop_size_code == 2'h3 && status_word.loop_count == $past(ctl_req.count);
    endproperty
    a_set_loop_count_op: assert property (p_set_loop_count_op) else $error("size code wrong");

    property p_loop;
        s_loop_hit |=> s_loop_taken ##0
            status_word.loop_count == $past(status_word.loop_count) - 12'h001;
    endproperty
    a_loop: assert property (p_loop) else $error("repeat redirect missing");

    property p_reserved;
        ctl_rsp.done && $past(ctl_req.sel) == CR_STATUS && $past(is_store)
        |-> ctl_rsp.illegal || (ctl_rsp.rdata[31] == 1'b0 && ctl_rsp.rdata[15:13] == 3'h0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

endmodule
`default_nettype wire

//--- verification/core_side_model.sv
// Core-side model: issues control, address generation, fetch, exception
// and T flag requests to the control register file, one per task call.
// Assumes a free-running mclk; answers arrive one cycle after the request.
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Core request model
// ****************************************
module core_side_model (
    input wire logic mclk,
    output cpu_ctl_pkg::ctl_req_s ctl_req,
    output logic exc_take,
    output logic [31:0] exc_pc,
    output logic tf_we,
    output logic tf_val,
    output cpu_ctl_pkg::agu_req_s agu_req,
    output logic fetch_valid,
    output logic [31:0] fetch_pc,
    input wire cpu_ctl_pkg::ctl_rsp_s ctl_rsp,
    input wire cpu_ctl_pkg::agu_rsp_s agu_rsp,
    input wire cpu_ctl_pkg::redirect_s loop_redirect
);
    import cpu_ctl_pkg::*;

    initial begin
        ctl_req = '0;
        agu_req = '0;
        exc_take = 1'b0;
        exc_pc = 32'h0;
        tf_we = 1'b0;
        tf_val = 1'b0;
        fetch_valid = 1'b0;
        fetch_pc = 32'h0;
    end

    // Released wdata, AGU addresses, fetch and exception PCs and T flag values are inverted so stale values never look valid
    task automatic ctl(input ctl_req_s r, output ctl_rsp_s s);
        @(posedge mclk);
        #1;
        ctl_req = r;
        @(posedge mclk);
        #1;
        s = ctl_rsp;
        ctl_req.valid = 1'b0;
        ctl_req.wdata = ~r.wdata;
    endtask

    task automatic agu(input mv_e k, input logic [31:0] a, output agu_rsp_s s);
        @(posedge mclk);
        #1;
        agu_req = '{valid: 1'b1, kind: k, addr: a};
        @(posedge mclk);
        #1;
        s = agu_rsp;
        agu_req = '{valid: 1'b0, kind: MV_NONE, addr: ~a};
    endtask

    task automatic fetch(input logic [31:0] pc, output redirect_s s);
        @(posedge mclk);
        #1;
        fetch_valid = 1'b1;
        fetch_pc = pc;
        @(posedge mclk);
        #1;
        s = loop_redirect;
        fetch_valid = 1'b0;
        fetch_pc = ~pc;
    endtask

    task automatic exc(input logic [31:0] pc);
        @(posedge mclk);
        #1;
        exc_take = 1'b1;
        exc_pc = pc;
        @(posedge mclk);
        #1;
        exc_take = 1'b0;
        exc_pc = ~pc;
    endtask

    task automatic tflag(input logic v);
        @(posedge mclk);
        #1;
        tf_we = 1'b1;
        tf_val = v;
        @(posedge mclk);
        #1;
        tf_we = 1'b0;
        tf_val = ~v;
    endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the control register file.
// Assumes core_side_model issues every request; the bench drives reset.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import cpu_ctl_pkg::*;
    logic mclk;
    logic srst;
    ctl_req_s ctl_req;
    ctl_rsp_s ctl_rsp;
    agu_req_s agu_req;
    agu_rsp_s agu_rsp;
    redirect_s loop_redirect;
    sw_s status_word;
    logic exc_take;
    logic [31:0] exc_pc;
    logic tf_we;
    logic tf_val;
    logic fetch_valid;
    logic [31:0] fetch_pc;
    logic [31:0] global_base_pointer;
    logic [31:0] vector_table_base;
    logic dsp_active;
    ctl_rsp_s rsp;
    agu_rsp_s arsp;
    redirect_s rr;
    logic [1:0] codes [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    int err_count = 0;
    int tests_run = 0;

    cpu_ctl_regs cpu_ctl_regs_i (.mclk(mclk), .srst(srst), .ctl_req(ctl_req),
        .exc_take(exc_take), .exc_pc(exc_pc), .tf_we(tf_we), .tf_val(tf_val),
        .agu_req(agu_req), .fetch_valid(fetch_valid), .fetch_pc(fetch_pc),
        .ctl_rsp(ctl_rsp), .agu_rsp(agu_rsp), .loop_redirect(loop_redirect),
        .status_word(status_word), .global_base_pointer(global_base_pointer),
        .vector_table_base(vector_table_base), .dsp_active(dsp_active));
    core_side_model core_side_model_i (.mclk(mclk), .ctl_req(ctl_req),
        .exc_take(exc_take), .exc_pc(exc_pc), .tf_we(tf_we), .tf_val(tf_val),
        .agu_req(agu_req), .fetch_valid(fetch_valid), .fetch_pc(fetch_pc),
        .ctl_rsp(ctl_rsp), .agu_rsp(agu_rsp), .loop_redirect(loop_redirect));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic rst();
        srst = 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        srst = 1'b0;
    endtask

    // One word carries disp, count; p carries pointer, PC and body length
    task automatic cop(input op_e op, input creg_e sel, input logic [31:0] w,
                       input logic [31:0] p);
        ctl_req_s r;
        r = '0;
        r.valid = 1'b1;
        r.op = op;
        r.sel = sel;
        r.wdata = w;
        r.ptr = p;
        r.pc = p;
        r.disp = w[7:0];
        r.count = w[11:0];
        r.body_len = p[7:0];
        core_side_model_i.ctl(r, rsp);
    endtask

    // Bounds stay at end 0040, start 0010 for every case
    task automatic agu_case(input logic [31:0] sw, input mv_e k, input logic [31:0] a,
                            input logic w);
        cop(OP_LDC, CR_STATUS, sw, 32'h0);
        core_side_model_i.agu(k, a, arsp);
        chk("agu valid", 32'h1, {31'h0, arsp.valid});
        chk("agu wrapped", {31'h0, w}, {31'h0, arsp.wrapped});
        chk("agu addr", w ? {a[31:16], 16'h0010} : a, arsp.addr);
    endtask

    task automatic loop_case(input logic [31:0] body, input logic [31:0] last);
        cop(OP_SET_LOOP_COUNT_OP, CR_STATUS, 32'h1, body);
        core_side_model_i.fetch(last, rr);
        chk("redirect", 32'h1, {31'h0, rr.valid});
        chk("redirect target", 32'h300, rr.target);
        chk("count after", 32'h0, {20'h0, status_word.loop_count});
        core_side_model_i.fetch(last, rr);
        chk("no redirect at zero", 32'h0, {31'h0, rr.valid});
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        rst();
        chk("status reset", 32'h700000F0, status_word);
        chk("dsp reset", 32'h0, {31'h0, dsp_active});
        chk("vector base reset", 32'h0, vector_table_base);
        $display("test reset finished");
        for (int i = 1; i < 8; i++) begin
            cop(OP_LDC, creg_e'(i), 32'h0ABC0F00 + 32'(i), 32'h0);
            cop(OP_STC, creg_e'(i), 32'h0, 32'h0);
            chk("control reg read", 32'h0ABC0F00 + 32'(i), rsp.rdata);
        end
        chk("global base", 32'h0ABC0F03, global_base_pointer);
        chk("vector base", 32'h0ABC0F04, vector_table_base);
        cop(OP_LDC_MEM, CR_REPEAT_BEGIN, 32'hCAFE0000, 32'h100);
        chk("post increment", 32'h104, rsp.ptr);
        chk("load done", 32'h1, {31'h0, rsp.done});
        chk("pointer write", 32'h1, {31'h0, rsp.ptr_we});
        cop(OP_STC_MEM, CR_REPEAT_BEGIN, 32'h0, 32'h200);
        chk("pre decrement", 32'h1FC, rsp.ptr);
        chk("stored word", 32'hCAFE0000, rsp.rdata);
        cop(OP_LOAD_BEGIN_OP, CR_REPEAT_BEGIN, 32'hFE, 32'h1000);
        cop(OP_STC, CR_REPEAT_BEGIN, 32'h0, 32'h0);
        chk("begin pointer", 32'hFFC, rsp.rdata);
        cop(OP_LOAD_LAST_OP, CR_LOOP_LAST, 32'h10, 32'h2000);
        cop(OP_STC, CR_LOOP_LAST, 32'h0, 32'h0);
        chk("last pointer", 32'h2020, rsp.rdata);
        $display("test registers finished");
        cop(OP_LDC, CR_STATUS, 32'hFFFFFFFF, 32'h0);
        chk("status reserved", 32'h7FFF1FFF, status_word);
        chk("dsp on", 32'h1, {31'h0, dsp_active});
        cop(OP_STC, CR_STATUS, 32'h0, 32'h0);
        chk("status read", 32'h7FFF1FFF, rsp.rdata);
        cop(OP_LDC, CR_STATUS, 32'h40001000, 32'h0);
        for (int k = 0; k < 4; k++) begin
            cop(OP_SET_LOOP_COUNT_OP, CR_STATUS, 32'h800 + 32'(k), 32'h1 + 32'(k));
            chk("loop code", {30'h0, codes[k]}, {30'h0, status_word.loop_size_code});
            chk("loop count", 32'h800 + 32'(k), {20'h0, status_word.loop_count});
        end
        cop(OP_LDC, CR_REPEAT_BEGIN, 32'h300, 32'h0);
        cop(OP_LDC, CR_LOOP_LAST, 32'h340, 32'h0);
        loop_case(32'h1, 32'h300);
        loop_case(32'h2, 32'h302);
        loop_case(32'h3, 32'h304);
        loop_case(32'h5, 32'h340);
        $display("test repeat finished");
        cop(OP_LDC, CR_BOUNDS, 32'h00400010, 32'h0);
        agu_case(32'h40001400, MV_X, 32'h00A00040, 1'b1);
        agu_case(32'h40001400, MV_X, 32'h00A00042, 1'b0);
        agu_case(32'h40001400, MV_Y, 32'h00A00040, 1'b0);
        agu_case(32'h40001800, MV_Y, 32'h00A00040, 1'b1);
        agu_case(32'h40001800, MV_SINGLE, 32'h00A00040, 1'b0);
        agu_case(32'h40001C00, MV_X, 32'h00A00040, 1'b0);
        agu_case(32'h40001C00, MV_Y, 32'h00A00040, 1'b1);
        agu_case(32'h40000C00, MV_Y, 32'h00A00040, 1'b0);
        $display("test wrap finished");
        core_side_model_i.tflag(1'b1);
        chk("t flag set", 32'h1, {31'h0, status_word.tf_flag});
        core_side_model_i.tflag(1'b0);
        chk("t flag clear", 32'h0, {31'h0, status_word.tf_flag});
        cop(OP_LDC, CR_STATUS, 32'h40001400, 32'h0);
        core_side_model_i.exc(32'h00008888);
        cop(OP_STC, CR_SAVED_PC, 32'h0, 32'h0);
        chk("saved pc", 32'h00008888, rsp.rdata);
        cop(OP_STC, CR_SAVED_STATUS, 32'h0, 32'h0);
        chk("saved status", 32'h40001400, rsp.rdata);
        $display("test exception finished");
        cop(OP_LDC, CR_STATUS, 32'h00001000, 32'h0);
        cop(OP_LDC, CR_STATUS, 32'hFFFFFFFF, 32'h0);
        chk("user dsp load", 32'h0, {31'h0, rsp.illegal});
        chk("user dsp status", 32'h0FFF1C00, status_word);
        cop(OP_STC, CR_STATUS, 32'h0, 32'h0);
        chk("user dsp read", 32'h0FFF1C00, rsp.rdata);
        cop(OP_SET_LOOP_COUNT_OP, CR_STATUS, 32'h5, 32'h2);
        chk("user loop code", 32'h1, {30'h0, status_word.loop_size_code});
        chk("user loop count", 32'h5, {20'h0, status_word.loop_count});
        rst();
        cop(OP_LDC, CR_STATUS, 32'h0, 32'h0);
        cop(OP_LDC, CR_STATUS, 32'hFFFFFFFF, 32'h0);
        chk("user load refused", 32'h1, {31'h0, rsp.illegal});
        chk("status kept", 32'h0, status_word);
        cop(OP_STC, CR_STATUS, 32'h0, 32'h0);
        chk("user store refused", 32'h1, {31'h0, rsp.illegal});
        $display("test modes finished");
        results();
    end

    // About 160 cycles of traffic; the 6000-cycle limit means a hang
    initial begin
        #60000;
        err_count++;
        results();
    end
endmodule
`default_nettype wire
